// >>> logic/ods_pkg.sv
package ods_pkg;
    // Bus and map geometry
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_LO0 = 10'h142;
    localparam logic [IDX_W-1:0] IDX_LO_EXT = 10'h150;
    localparam logic [IDX_W-1:0] IDX_HI0 = 10'h242;
    localparam logic [IDX_W-1:0] IDX_HI1 = 10'h243;
    localparam logic [IDX_W-1:0] IDX_HI2 = 10'h246;
    localparam logic [IDX_W-1:0] IDX_STRAP = 10'h300;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h301;
    localparam int NUM_LO = 8;
    localparam int NUM_HI = 3;
    // Low-group control fields
    localparam int LO_FMT_LSB = 0;
    localparam int LO_PD_BIT = 2;
    // High-group control fields
    localparam int HI_ON_BIT = 0;
    localparam int HI_STR_BIT = 1;
    localparam int HI_POL_LSB = 2;
    localparam int HI_FMT_LSB = 4;
    localparam int HI_FS_BIT = 7;
    // Format codes
    localparam logic [1:0] LO_HSTL = 2'h0;
    localparam logic [1:0] LO_LVDS = 2'h1;
    localparam logic [1:0] LO_CMOS18 = 2'h2;
    localparam logic [2:0] HI_HSTL = 3'h0;
    localparam logic [2:0] HI_CMOS18 = 3'h1;
    localparam logic [2:0] HI_LVDS = 3'h2;
    localparam logic [2:0] HI_HCSL = 3'h3;
    localparam logic [2:0] HI_CMOSFS = 3'h4;
    // Reference receiver codes
    localparam logic [1:0] RX_XTAL = 2'h0;
    localparam logic [1:0] RX_CMOS = 2'h1;
    localparam logic [1:0] RX_DIFF = 2'h2;
    // Reset values
    localparam logic [7:0] LO_RST = 8'h04;
    localparam logic [7:0] HI_RST = 8'h00;
    // Strap scan
    localparam int NUM_STRAPS = 4;
    localparam int STRAP_W = 3;
    localparam int CLK_NS = 20;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
endpackage : ods_pkg

// >>> logic/ods_strap_scan.sv
module ods_strap_scan (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Sense front end
    input wire logic [2:0] i_level,
    output logic [1:0] o_sel,
    // Results
    output logic [11:0] o_states,
    output logic o_done,
    output logic o_done_pulse
);
    typedef enum logic [2:0] {
        ODS_SETTLE = 3'h1,
        ODS_SAMPLE = 3'h2,
        ODS_DONE = 3'h4
    } ods_scan_t;

    ods_scan_t state;
    logic [ods_pkg::CNT_W-1:0] cnt;
    wire settled = (cnt == ods_pkg::CNT_W'(ods_pkg::SETTLE_CYC - 1));
    wire last_pin = (o_sel == 2'(ods_pkg::NUM_STRAPS - 1));

    // Each pin is selected, allowed to settle, then sampled; reset restarts it
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state <= ODS_SETTLE;
            cnt <= '0;
            o_sel <= 2'h0;
            o_states <= 12'h000;
            o_done_pulse <= 1'b0;
        end else begin
            o_done_pulse <= 1'b0;
            case (state)
                ODS_SETTLE: begin
                    cnt <= settled ? '0 : cnt + 1'b1;
                    if (settled) state <= ODS_SAMPLE;
                end
                ODS_SAMPLE: begin
                    o_states[o_sel*ods_pkg::STRAP_W +: ods_pkg::STRAP_W] <= i_level;
                    if (last_pin) begin
                        state <= ODS_DONE;
                        o_done_pulse <= 1'b1;
                    end else begin
                        o_sel <= o_sel + 2'h1;
                        state <= ODS_SETTLE;
                    end
                end
                ODS_DONE: state <= ODS_DONE;
                default: state <= ODS_SETTLE;
            endcase
        end
    end

    assign o_done = (state == ODS_DONE);
endmodule : ods_strap_scan

// >>> logic/ods_strap_decode.sv
module ods_strap_decode (
    // Scanned states
    input wire logic [2:0] i_ref,
    input wire logic [2:0] i_last,
    input wire logic [2:0] i_a,
    input wire logic [2:0] i_b,
    // Decoded defaults
    output logic [1:0] o_ref_ab,
    output logic [1:0] o_ref_c,
    output logic o_int_src_c,
    output logic o_frac_dbl,
    output logic [7:0] o_lo_reg,
    output logic [7:0] o_hi_reg,
    output logic [7:0] o_last_reg,
    output logic o_last_src_ref
);
    wire ab_xtal = (i_ref == 3'h0) || (i_ref == 3'h4);
    wire ab_diff = (i_ref == 3'h3) || (i_ref == 3'h6) || (i_ref == 3'h7);
    wire off = (i_a == 3'h0) && (i_b == 3'h0);
    wire last_cmos = !i_last[2];

    // Receiver setup and integer PLL source select
    assign o_ref_ab = ab_xtal ? ods_pkg::RX_XTAL : (ab_diff ? ods_pkg::RX_DIFF : ods_pkg::RX_CMOS);
    assign o_ref_c = (i_ref == 3'h4 || i_ref == 3'h6) ? ods_pkg::RX_XTAL : ods_pkg::RX_CMOS;
    assign o_int_src_c = i_ref[2];
    assign o_frac_dbl = !(i_ref == 3'h2 || i_ref == 3'h3);
    // First ten outputs: disabled for the all-zero pair, otherwise HSTL and on
    assign o_lo_reg = off ? ods_pkg::LO_RST : {6'h00, ods_pkg::LO_HSTL};
    assign o_hi_reg = off ? ods_pkg::HI_RST : {1'b0, ods_pkg::HI_HSTL, 4'h1};
    // Last output: full-swing CMOS below state 4, LVDS from state 4 up
    assign o_last_reg = last_cmos ? {1'b1, ods_pkg::HI_CMOSFS, 4'h1}
                                  : {1'b0, ods_pkg::HI_LVDS, 4'h1};
    assign o_last_src_ref = (i_last == 3'h0);
endmodule : ods_strap_decode

// >>> logic/ods_top.sv
// What this block does
// - Each low-group driver has a power-down bit, first at 0x142 bit 2.
// - Each high-group driver has an enable bit, first at 0x242 bit 0.
// - Each low-group driver has a two-bit format field at bits 1:0.
// - Low-group 1.8 V CMOS drops termination and drives pins in antiphase.
// - High-group drivers have a three-bit format field at bits 6:4.
// - In CMOS, bit 7 picks 1.8 V swing or supply swing.
// - In CMOS, bits 3:2 set the polarity the driver applies.
// - In LVDS, bit 1 picks 3.5 mA or 4.5 mA.
// - In full-swing CMOS bit 1 picks low strength; 1.8 V CMOS always low.
// - All four strap pins are scanned after every reset.
// - Each scan resolves one of eight states, setting that pin's function.
// - States 0-3 pull down, 4-7 pull up, four resistor values.
// - Reference strap sets receiver setup and integer PLL source.
// - Reference strap sets the fractional doubler enable; the integer doubler enable is held off.
// - Last-output strap sets frequency, format and source of last output.
// - The two remaining straps set fractional translation and first ten outputs.
// - Last output: state 0 25 MHz CMOS from reference, 4-7 LVDS.
//
// The Avalon-MM interface to the registers was decided locally.
module ods_top (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    // Avalon-MM slave
    input wire logic [ods_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Strap sense front end
    input wire logic [2:0] I_STRAP_LEVEL,
    output logic [1:0] O_STRAP_SEL,
    // Low-group driver controls
    output logic [7:0] O_LO_PD,
    output logic [15:0] O_LO_FMT,
    output logic [7:0] O_LO_TERM_ON,
    output logic [7:0] O_LO_ANTIPHASE,
    // High-group driver controls
    output logic [2:0] O_HI_ON,
    output logic [8:0] O_HI_FMT,
    output logic [2:0] O_HI_FULL_SWING,
    output logic [5:0] O_HI_POL,
    output logic [2:0] O_HI_LVDS_4P5MA,
    output logic [2:0] O_HI_LOW_STRENGTH,
    // Strap derived configuration
    output logic [1:0] O_REF_AB_CFG,
    output logic [1:0] O_REF_C_CFG,
    output logic O_INT_PLL_SRC_C,
    output logic O_FRAC_DBL_EN,
    output logic O_INT_DBL_EN,
    output logic O_LAST_SRC_REF,
    output logic [2:0] O_LAST_FREQ_SEL,
    output logic [5:0] O_FRAC_CFG,
    output logic O_STRAP_DONE
);
    // True for either CMOS code of a high-group format field
    function automatic logic hi_cmos(input logic [2:0] f);
        hi_cmos = (f == ods_pkg::HI_CMOS18) || (f == ods_pkg::HI_CMOSFS);
    endfunction : hi_cmos

    // Register index of low-group driver n
    function automatic logic [ods_pkg::IDX_W-1:0] lo_idx(input int n);
        lo_idx = (n == 0) ? ods_pkg::IDX_LO0 : ods_pkg::IDX_W'(ods_pkg::IDX_LO_EXT + n - 1);
    endfunction : lo_idx

    logic [7:0] lo_reg [ods_pkg::NUM_LO];
    logic [7:0] hi_reg [ods_pkg::NUM_HI];
    logic ack;
    logic [11:0] strap_states;
    logic scan_done;
    logic scan_pulse;
    logic [1:0] dec_ref_ab;
    logic [1:0] dec_ref_c;
    logic dec_int_src_c;
    logic dec_frac_dbl;
    logic [7:0] dec_lo;
    logic [7:0] dec_hi;
    logic [7:0] dec_last;
    logic dec_last_src;

    // Strap scanner: sequenced over a shared sense path after each reset
    ods_strap_scan u_scan (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .i_level(I_STRAP_LEVEL),
        .o_sel(O_STRAP_SEL),
        .o_states(strap_states),
        .o_done(scan_done),
        .o_done_pulse(scan_pulse)
    );

    // Strap state translation
    ods_strap_decode u_dec (
        .i_ref(strap_states[2:0]),
        .i_last(strap_states[5:3]),
        .i_a(strap_states[8:6]),
        .i_b(strap_states[11:9]),
        .o_ref_ab(dec_ref_ab),
        .o_ref_c(dec_ref_c),
        .o_int_src_c(dec_int_src_c),
        .o_frac_dbl(dec_frac_dbl),
        .o_lo_reg(dec_lo),
        .o_hi_reg(dec_hi),
        .o_last_reg(dec_last),
        .o_last_src_ref(dec_last_src)
    );

    // Bus decode; byte address is four times the register index
    wire req = I_AVS_READ || I_AVS_WRITE;
    wire aligned = (I_AVS_ADDRESS[1:0] == 2'h0);
    wire [ods_pkg::IDX_W-1:0] idx = I_AVS_ADDRESS[ods_pkg::ADDR_W-1:2];
    wire wr_go = I_AVS_WRITE && ack && aligned && I_AVS_BYTEENABLE[0];
    wire hit_hi0 = aligned && (idx == ods_pkg::IDX_HI0);
    wire hit_hi1 = aligned && (idx == ods_pkg::IDX_HI1);
    wire hit_hi2 = aligned && (idx == ods_pkg::IDX_HI2);
    wire hit_strap = aligned && (idx == ods_pkg::IDX_STRAP);
    wire hit_stat = aligned && (idx == ods_pkg::IDX_STATUS);
    logic [ods_pkg::NUM_LO-1:0] hit_lo;
    logic [ods_pkg::NUM_HI-1:0] hit_hi;
    assign hit_hi = {hit_hi2, hit_hi1, hit_hi0};

    // Requests stall until the strap defaults are in place, then answer in one cycle
    assign O_AVS_WAITREQUEST = req && !ack;

    // One-cycle acknowledge; never raised while the scan is still running
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack && scan_done;
        end
    end

    // Low-group register file; the scan default overrides any earlier write
    for (genvar n = 0; n < ods_pkg::NUM_LO; n++) begin : g_lo
        assign hit_lo[n] = aligned && (idx == lo_idx(n));
        always_ff @(posedge I_MCLK) begin
            if (!I_RST_B) begin
                lo_reg[n] <= ods_pkg::LO_RST;
            end else if (scan_pulse) begin
                lo_reg[n] <= dec_lo;
            end else if (wr_go && hit_lo[n]) begin
                lo_reg[n] <= I_AVS_WRITEDATA[7:0];
            end
        end
    end

    // High-group register file; the last output takes its own strap default
    for (genvar h = 0; h < ods_pkg::NUM_HI; h++) begin : g_hi
        always_ff @(posedge I_MCLK) begin
            if (!I_RST_B) begin
                hi_reg[h] <= ods_pkg::HI_RST;
            end else if (scan_pulse) begin
                hi_reg[h] <= (h == ods_pkg::NUM_HI - 1) ? dec_last : dec_hi;
            end else if (wr_go && hit_hi[h]) begin
                hi_reg[h] <= I_AVS_WRITEDATA[7:0];
            end
        end
    end

    // Read mux; unmapped or unaligned addresses read as zero
    logic [7:0] rd_lo;
    always_comb begin
        rd_lo = 8'h00;
        for (int n = 0; n < ods_pkg::NUM_LO; n++) begin
            if (hit_lo[n]) rd_lo = lo_reg[n];
        end
    end
    wire [31:0] rd_val = hit_hi0 ? {24'h000000, hi_reg[0]}
                       : hit_hi1 ? {24'h000000, hi_reg[1]}
                       : hit_hi2 ? {24'h000000, hi_reg[2]}
                       : hit_strap ? {20'h00000, strap_states}
                       : hit_stat ? {31'h00000000, scan_done}
                       : {24'h000000, rd_lo};

    // Read data stands in the cycle where waitrequest drops
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
            O_AVS_READDATA <= 32'h00000000;
        end else if (I_AVS_READ && !ack && scan_done) begin
            O_AVS_READDATA <= rd_val;
        end
    end

    // Derived driver controls, decoded combinationally per driver
    logic [7:0] next_lo_pd;
    logic [15:0] next_lo_fmt;
    logic [7:0] next_lo_cmos;
    logic [2:0] next_hi_on;
    logic [8:0] next_hi_fmt;
    logic [2:0] next_hi_fs;
    logic [5:0] next_hi_pol;
    logic [2:0] next_hi_4p5;
    logic [2:0] next_hi_low;
    always_comb begin
        logic [2:0] f;
        f = 3'h0;
        for (int n = 0; n < ods_pkg::NUM_LO; n++) begin
            next_lo_pd[n] = lo_reg[n][ods_pkg::LO_PD_BIT];
            next_lo_fmt[2*n +: 2] = lo_reg[n][ods_pkg::LO_FMT_LSB +: 2];
            next_lo_cmos[n] = (lo_reg[n][ods_pkg::LO_FMT_LSB +: 2] == ods_pkg::LO_CMOS18);
        end
        for (int h = 0; h < ods_pkg::NUM_HI; h++) begin
            f = hi_reg[h][ods_pkg::HI_FMT_LSB +: 3];
            next_hi_on[h] = hi_reg[h][ods_pkg::HI_ON_BIT];
            next_hi_fmt[3*h +: 3] = f;
            // Swing is qualified by format so a stray bit 7 cannot leak into HSTL or LVDS
            next_hi_fs[h] = hi_cmos(f) && hi_reg[h][ods_pkg::HI_FS_BIT];
            next_hi_pol[2*h +: 2] = hi_cmos(f) ? hi_reg[h][ods_pkg::HI_POL_LSB +: 2] : 2'h0;
            next_hi_4p5[h] = (f == ods_pkg::HI_LVDS) && hi_reg[h][ods_pkg::HI_STR_BIT];
            next_hi_low[h] = (f == ods_pkg::HI_CMOS18)
                          || ((f == ods_pkg::HI_CMOSFS) && hi_reg[h][ods_pkg::HI_STR_BIT]);
        end
    end

    // Output flops for the driver controls
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
            O_LO_PD <= 8'hFF;
            O_LO_FMT <= 16'h0000;
            O_LO_TERM_ON <= 8'hFF;
            O_LO_ANTIPHASE <= 8'h00;
            O_HI_ON <= 3'h0;
            O_HI_FMT <= 9'h000;
            O_HI_FULL_SWING <= 3'h0;
            O_HI_POL <= 6'h00;
            O_HI_LVDS_4P5MA <= 3'h0;
            O_HI_LOW_STRENGTH <= 3'h0;
        end else begin
            O_LO_PD <= next_lo_pd;
            O_LO_FMT <= next_lo_fmt;
            O_LO_TERM_ON <= ~next_lo_cmos;
            O_LO_ANTIPHASE <= next_lo_cmos;
            O_HI_ON <= next_hi_on;
            O_HI_FMT <= next_hi_fmt;
            O_HI_FULL_SWING <= next_hi_fs;
            O_HI_POL <= next_hi_pol;
            O_HI_LVDS_4P5MA <= next_hi_4p5;
            O_HI_LOW_STRENGTH <= next_hi_low;
        end
    end

    // Strap configuration outputs, latched once per scan
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
            O_REF_AB_CFG <= ods_pkg::RX_XTAL;
            O_REF_C_CFG <= ods_pkg::RX_CMOS;
            O_INT_PLL_SRC_C <= 1'b0;
            O_FRAC_DBL_EN <= 1'b0;
            O_INT_DBL_EN <= 1'b0;
            O_LAST_SRC_REF <= 1'b0;
            O_LAST_FREQ_SEL <= 3'h0;
            O_FRAC_CFG <= 6'h00;
        end else if (scan_pulse) begin
            O_REF_AB_CFG <= dec_ref_ab;
            O_REF_C_CFG <= dec_ref_c;
            O_INT_PLL_SRC_C <= dec_int_src_c;
            O_FRAC_DBL_EN <= dec_frac_dbl;
            O_INT_DBL_EN <= 1'b0;
            O_LAST_SRC_REF <= dec_last_src;
            O_LAST_FREQ_SEL <= strap_states[5:3];
            O_FRAC_CFG <= strap_states[11:6];
        end
    end

    assign O_STRAP_DONE = scan_done;

    // Assertions
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_write_lo0;
        I_AVS_WRITE && ack && (I_AVS_ADDRESS == {ods_pkg::IDX_LO0, 2'h0}) && I_AVS_BYTEENABLE[0] && !scan_pulse;
    endsequence
    sequence s_scan_end;
        scan_pulse;
    endsequence

    a_lo0_pd_out: assert property (s_write_lo0 |-> ##2 O_LO_PD[0] == $past(I_AVS_WRITEDATA[2], 2))
        else $error("low driver 0 power-down did not follow write");
    a_hi_on_out: assert property (O_HI_ON[0] == $past(hi_reg[0][0]))
        else $error("high driver 0 enable mismatch");
    a_lo_fmt_out: assert property (s_write_lo0 |-> ##2 O_LO_FMT[1:0] == $past(I_AVS_WRITEDATA[1:0], 2))
        else $error("low driver 0 format mismatch");
    a_cmos_term_off: assert property (O_LO_ANTIPHASE[0] |-> !O_LO_TERM_ON[0] && O_LO_FMT[1:0] == ods_pkg::LO_CMOS18)
        else $error("CMOS low driver kept termination");
    a_fs_needs_cmos: assert property (O_HI_FULL_SWING[2] |-> hi_cmos(O_HI_FMT[8:6]))
        else $error("full swing outside CMOS");
    a_pol_cmos_only: assert property (!hi_cmos(O_HI_FMT[2:0]) |-> O_HI_POL[1:0] == 2'h0)
        else $error("polarity applied outside CMOS");
    a_lvds_strength: assert property (O_HI_LVDS_4P5MA[1] |-> O_HI_FMT[5:3] == ods_pkg::HI_LVDS)
        else $error("4.5 mA outside LVDS");
    a_cmos18_low: assert property (O_HI_FMT[8:6] == ods_pkg::HI_CMOS18 |-> O_HI_LOW_STRENGTH[2])
        else $error("1.8 V CMOS not low strength");
    a_scan_bounded: assert property ($rose(I_RST_B) |-> ##[1:410] scan_pulse)
        else $error("strap scan did not finish");
    a_last_default: assert property (s_scan_end |=> hi_reg[2][6:4] ==
                                     (strap_states[5] ? ods_pkg::HI_LVDS : ods_pkg::HI_CMOSFS))
        else $error("last output default not loaded");
    a_wait_scan: assert property (!scan_done && req |-> O_AVS_WAITREQUEST)
        else $error("bus answered before scan finished");

    // Each low driver's controls trail its register by one edge
    for (genvar n = 0; n < ods_pkg::NUM_LO; n++) begin : g_lo_chk
        a_lo_pd_each: assert property (O_LO_PD[n] == $past(lo_reg[n][ods_pkg::LO_PD_BIT]))
            else $error("low driver power-down mismatch");
        a_lo_fmt_each: assert property (O_LO_FMT[2*n +: 2] == $past(lo_reg[n][ods_pkg::LO_FMT_LSB +: 2]))
            else $error("low driver format mismatch");
        a_lo_cmos_each: assert property (O_LO_ANTIPHASE[n] ==
                                         $past(lo_reg[n][ods_pkg::LO_FMT_LSB +: 2] == ods_pkg::LO_CMOS18))
            else $error("low driver CMOS mode mismatch");
    end

    // Each high driver; strength and swing bits only count in the formats that use them
    for (genvar h = 0; h < ods_pkg::NUM_HI; h++) begin : g_hi_chk
        a_hi_on_each: assert property (O_HI_ON[h] == $past(hi_reg[h][ods_pkg::HI_ON_BIT]))
            else $error("high driver enable mismatch");
        a_hi_fmt_each: assert property (O_HI_FMT[3*h +: 3] == $past(hi_reg[h][ods_pkg::HI_FMT_LSB +: 3]))
            else $error("high driver format mismatch");
        a_hi_swing_bit: assert property (hi_cmos(O_HI_FMT[3*h +: 3])
                                         |-> O_HI_FULL_SWING[h] == $past(hi_reg[h][ods_pkg::HI_FS_BIT]))
            else $error("CMOS swing does not follow its bit");
        a_hi_lvds_drive: assert property (O_HI_FMT[3*h +: 3] == ods_pkg::HI_LVDS
                                          |-> O_HI_LVDS_4P5MA[h] == $past(hi_reg[h][ods_pkg::HI_STR_BIT]))
            else $error("LVDS strength does not follow its bit");
        a_hi_fs_drive: assert property (O_HI_FMT[3*h +: 3] == ods_pkg::HI_CMOSFS
                                        |-> O_HI_LOW_STRENGTH[h] == $past(hi_reg[h][ods_pkg::HI_STR_BIT]))
            else $error("CMOS strength does not follow its bit");
    end

    // Pins are sensed in order and the results stand until the next reset
    sequence s_sel_moves;
        !$stable(O_STRAP_SEL);
    endsequence
    a_sel_in_order: assert property (s_sel_moves |-> O_STRAP_SEL == $past(O_STRAP_SEL) + 2'h1)
        else $error("strap pins sensed out of order");
    a_done_holds: assert property (scan_done |=> scan_done)
        else $error("scan done dropped without reset");
    a_frac_latch: assert property (s_scan_end |=> O_FRAC_CFG == strap_states[11:6])
        else $error("fractional strap not latched");
    a_src_latch: assert property (s_scan_end |=> O_INT_PLL_SRC_C == strap_states[2])
        else $error("integer PLL source not latched");
endmodule : ods_top

// >>> testbench/ods_strap_board.sv
module ods_strap_board #(
    parameter bit REF_AB_25MHZ = 1'b1
) (
    // Strap being sensed
    input wire logic [1:0] i_sel,
    input wire logic [11:0] i_straps,
    // Resolved state of that pin
    output logic [2:0] o_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] fitted;
    // Board routes the integer PLL to the third input when the first inputs are not 25 MHz
    assign fitted = REF_AB_25MHZ ? i_straps : (i_straps | 12'h004);
    // Resistor value and terminus arrive already resolved to a state 0..7
    assign o_level = fitted[i_sel*3 +: 3];
endmodule : ods_strap_board

// >>> testbench/ods_top_tb.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module ods_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    int n_mismatch = 0;
    int compares = 0;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] ben = 4'h1;
    logic [31:0] rdata, rx;
    logic wait_req, int_c, frac_dbl, int_dbl, last_ref, done;
    logic [2:0] level, hi_on, hi_fs, hi_4p5, hi_low, last_freq;
    logic [1:0] sel, ref_ab, ref_c;
    logic [11:0] straps = 12'h000;
    logic [7:0] lo_pd, lo_term, lo_anti;
    logic [15:0] lo_fmt;
    logic [8:0] hi_fmt;
    logic [5:0] hi_pol, frac_cfg;

    // 50 MHz clock
    always #10 mclk = ~mclk;

    ods_top i_ods_top (.I_MCLK(mclk), .I_RST_B(rst_b), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(ben), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wait_req), .I_STRAP_LEVEL(level), .O_STRAP_SEL(sel), .O_LO_PD(lo_pd),
        .O_LO_FMT(lo_fmt), .O_LO_TERM_ON(lo_term), .O_LO_ANTIPHASE(lo_anti), .O_HI_ON(hi_on),
        .O_HI_FMT(hi_fmt), .O_HI_FULL_SWING(hi_fs), .O_HI_POL(hi_pol), .O_HI_LVDS_4P5MA(hi_4p5),
        .O_HI_LOW_STRENGTH(hi_low), .O_REF_AB_CFG(ref_ab), .O_REF_C_CFG(ref_c),
        .O_INT_PLL_SRC_C(int_c), .O_FRAC_DBL_EN(frac_dbl), .O_INT_DBL_EN(int_dbl),
        .O_LAST_SRC_REF(last_ref), .O_LAST_FREQ_SEL(last_freq), .O_FRAC_CFG(frac_cfg),
        .O_STRAP_DONE(done));

    ods_strap_board i_ods_strap_board (.i_sel(sel), .i_straps(straps), .o_level(level));

    // Receiver setup expected for each reference strap state
    function automatic logic [1:0] exp_ref_ab(input logic [2:0] s);
        case (s)
            3'h0, 3'h4: return ods_pkg::RX_XTAL;
            3'h3, 3'h6, 3'h7: return ods_pkg::RX_DIFF;
            default: return ods_pkg::RX_CMOS;
        endcase
    endfunction : exp_ref_ab

    // One Avalon transfer; waits for the slave, which stalls for the whole strap scan
    task automatic bus(input logic is_wr, input logic [9:0] idx, input logic [7:0] d);
        @(posedge mclk);
        addr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        rd <= !is_wr;
        wr <= is_wr;
        // No cycle limit here: a slave that never answers is left to the watchdog
        do begin
            @(posedge mclk);
        end while (wait_req !== 1'b0);
        rx = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // Reset with new straps, then check every strap-derived output
    task automatic scan(input logic [11:0] s);
        @(posedge mclk);
        straps <= s;
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        bus(1'b0, ods_pkg::IDX_STATUS, 8'h00);
        `CHK(done, 1'b1)
        `CHK(rx[0], 1'b1)
        `CHK(sel, 2'h3)
        bus(1'b0, ods_pkg::IDX_STRAP, 8'h00);
        `CHK(rx, {20'h0, s})
        `CHK(ref_ab, exp_ref_ab(s[2:0]))
        `CHK(ref_c, (s[2:0] == 3'h4 || s[2:0] == 3'h6) ? ods_pkg::RX_XTAL : ods_pkg::RX_CMOS)
        `CHK(int_c, s[2])
        `CHK(frac_dbl, !(s[2:0] == 3'h2 || s[2:0] == 3'h3))
        `CHK(int_dbl, 1'b0)
        `CHK(last_ref, s[5:3] == 3'h0)
        `CHK(last_freq, s[5:3])
        `CHK(frac_cfg, s[11:6])
        `CHK(lo_pd, (s[11:6] == 6'h0) ? 8'hFF : 8'h00)
        `CHK(hi_on[2], 1'b1)
        `CHK(hi_fmt[8:6], s[5] ? ods_pkg::HI_LVDS : ods_pkg::HI_CMOSFS)
        bus(1'b0, ods_pkg::IDX_HI2, 8'h00);
        `CHK(rx[7:0], s[5] ? 8'h21 : 8'hC1)
    endtask : scan

    // Program a low-group driver and check its decoded controls
    task automatic lo_case(input int d, input logic [7:0] v);
        logic [9:0] idx;
        idx = (d == 0) ? ods_pkg::IDX_LO0 : ods_pkg::IDX_LO_EXT + 10'(d - 1);
        bus(1'b1, idx, v);
        repeat (2) @(posedge mclk);
        `CHK(lo_pd[d], v[2])
        `CHK(lo_fmt[d*2 +: 2], v[1:0])
        `CHK(lo_term[d], v[1:0] != ods_pkg::LO_CMOS18)
        `CHK(lo_anti[d], v[1:0] == ods_pkg::LO_CMOS18)
        bus(1'b0, idx, 8'h00);
        `CHK(rx, {24'h0, v})
    endtask : lo_case

    // Program a high-group driver and check its decoded controls
    task automatic hi_case(input int d, input logic [7:0] v);
        logic [9:0] idx;
        logic cm;
        idx = (d == 0) ? ods_pkg::IDX_HI0 : (d == 1) ? ods_pkg::IDX_HI1 : ods_pkg::IDX_HI2;
        cm = (v[6:4] == ods_pkg::HI_CMOS18) || (v[6:4] == ods_pkg::HI_CMOSFS);
        bus(1'b1, idx, v);
        repeat (2) @(posedge mclk);
        `CHK(hi_on[d], v[0])
        `CHK(hi_fmt[d*3 +: 3], v[6:4])
        `CHK(hi_fs[d], v[7] & cm)
        `CHK(hi_pol[d*2 +: 2], cm ? v[3:2] : 2'h0)
        `CHK(hi_4p5[d], (v[6:4] == ods_pkg::HI_LVDS) & v[1])
        `CHK(hi_low[d], (v[6:4] == ods_pkg::HI_CMOS18) | ((v[6:4] == ods_pkg::HI_CMOSFS) & v[1]))
        bus(1'b0, idx, 8'h00);
        `CHK(rx, {24'h0, v})
    endtask : hi_case

    // Verdict; shared by the main sequence and the watchdog
    task automatic test_done();
        $display("Counts: compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // Main sequence: every state of the reference and last-output straps, then every driver format
    initial begin
        logic [7:0] v;
        logic [7:0] lo0_last;
        void'($urandom(32'h268707c6));
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            scan({(k == 0) ? 6'h0 : 6'($urandom), 3'(7 - k), 3'(k)});
        end
        $display("test strap scan done");
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            v[1:0] = 2'(i % 3);
            lo_case(i % 8, v);
            if (i % 8 == 0) lo0_last = v;
        end
        $display("test low drivers done");
        for (int i = 0; i < 30; i++) begin
            v = 8'($urandom);
            v[6:4] = 3'(i % 5);
            if (v[6:4] != ods_pkg::HI_CMOS18 && v[6:4] != ods_pkg::HI_CMOSFS) v[7] = 1'b0;
            hi_case(i % 3, v);
        end
        $display("test high drivers done");
        // Unmapped place reads zero; a write without lane 0 is dropped
        bus(1'b1, 10'h144, 8'h5A);
        bus(1'b0, 10'h144, 8'h00);
        `CHK(rx, 32'h0)
        ben <= 4'h0;
        bus(1'b1, ods_pkg::IDX_LO0, 8'hFF);
        ben <= 4'h1;
        bus(1'b0, ods_pkg::IDX_LO0, 8'h00);
        `CHK(rx[7:0], lo0_last)
        `CHK(lo_pd[0], lo0_last[2])
        $display("test unmapped done");
        test_done();
    end

    // Watchdog well beyond the expected run of some 3700 cycles
    initial begin
        #(20000 * 20);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule : ods_top_tb
